/* File: sgp_consts.svh */
// sgp_consts.svh: offsets, field positions, reset values and timing counts
// for the shared 32-pin general purpose port.
// assumes: included by bare name; holds definitions only.
// Operation
// - thirty-two pins, one bit each per register
// - function bit wins; else direction picks in/out
// - reset leaves all pins as undriven inputs
// - inputs sampled at most every 128 ns
// - unused alternate function held inactive internally
// - general inputs captured into data register bit
// - data read returns sampled level, any role
// - general outputs drive their data register bit
// - pin 5 alternate is active-low event output
// - pins 6-12 alternate drive downstream resets 1-7
// - pins 21-24,31 alternate take expander interrupts
// - registers live in upstream configuration space
`ifndef SGP_CONSTS_SVH
`define SGP_CONSTS_SVH

// register byte offsets inside the upstream port configuration space
`define SGP_ADDR_W          12
`define SGP_OFF_FUNC        12'h210
`define SGP_OFF_DIR         12'h214
`define SGP_OFF_DATA        12'h218

// reset values: all general inputs, alternates off, data clear
`define SGP_RST_FUNC        32'h0000_0000
`define SGP_RST_DIR         32'h0000_0000
`define SGP_RST_DATA        32'h0000_0000

// pin count and alternate function pin positions
`define SGP_NUM_PINS        32
`define SGP_PIN_EVENT       5
`define SGP_PIN_DRST_LO     6
`define SGP_NUM_DRST        7
`define SGP_ALT_OUT_MASK    32'h0000_1FE0
`define SGP_PIN_IRQ0        21
`define SGP_PIN_IRQ10       31
`define SGP_NUM_IRQ         5

// input sampling interval: least time, rounded up to whole cycles
`define SGP_CLK_NS          25
`define SGP_SAMPLE_NS       128
`define SGP_SAMPLE_CYC      ((`SGP_SAMPLE_NS + `SGP_CLK_NS - 1) / `SGP_CLK_NS)

`endif

/* File: sgp_pkg.sv */
// sgp_pkg.sv: types shared by the general purpose port files.
// assumes: constants come from sgp_consts.svh.
`include "sgp_consts.svh"

package sgp_pkg;

  // one configuration space access, taken in a single cycle
  typedef struct packed {
    logic                     req;
    logic                     wr;
    logic [`SGP_ADDR_W-1:0]   addr;
    logic [31:0]              wdata;
  } sgp_cfg_req_t;

  // answer to an access, one cycle after it is taken
  typedef struct packed {
    logic        ack;
    logic        hit;
    logic [31:0] rdata;
  } sgp_cfg_rsp_t;

endpackage

/* File: sgp_sync.sv */
// sgp_sync.sv: two-flop synchroniser for a vector of pin levels.
// assumes: one clock; bits are independent asynchronous levels.
`timescale 1ns/100ps
`default_nettype none

module sgp_sync #(
  parameter int WIDTH = 32
) (
  // clock and reset
  input  wire logic             clock,
  input  wire logic             rst_b,
  // levels
  input  wire logic [WIDTH-1:0] d,
  output var  logic [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_reg;

  // first stage feeds only the second stage
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      meta_reg <= '0;
      q        <= '0;
    end else begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end

endmodule

`default_nettype wire

/* File: sgp_gpio_port.sv */
// sgp_gpio_port.sv: 32-pin general purpose port with shared alternates.
// assumes: configuration accesses come from the upstream port's space;
// pin wires are resolved outside from pin_out and pin_oe.
`timescale 1ns/100ps
`default_nettype none
`include "sgp_consts.svh"

module sgp_gpio_port #(
  parameter int NUM_PINS   = `SGP_NUM_PINS,
  parameter int SAMPLE_CYC = `SGP_SAMPLE_CYC
) (
  // clock and reset
  input  wire logic                 clock,
  input  wire logic                 rst_b,
  // upstream configuration space access
  input  wire sgp_pkg::sgp_cfg_req_t cfg_req,
  output var  sgp_pkg::sgp_cfg_rsp_t cfg_rsp,
  // pins
  input  wire logic [NUM_PINS-1:0]  pin_in,
  output var  logic [NUM_PINS-1:0]  pin_out,
  output var  logic [NUM_PINS-1:0]  pin_oe,
  // alternate function sources inside the device
  input  wire logic                 event_src_n,
  input  wire logic [6:0]           down_reset_src_n,
  // alternate function inputs delivered to the device
  output var  logic [4:0]           expander_irq_n
);

  localparam int CNT_W = (SAMPLE_CYC > 1) ? $clog2(SAMPLE_CYC) : 1;
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(SAMPLE_CYC - 1);

  // refuse pin counts the pin map cannot serve and sample intervals below the least one
  if (NUM_PINS != `SGP_NUM_PINS) begin : g_bad_pins
    $error("sgp_gpio_port: NUM_PINS must be 32");
  end
  if (SAMPLE_CYC < `SGP_SAMPLE_CYC) begin : g_bad_cyc
    $error("sgp_gpio_port: SAMPLE_CYC shorter than the least interval");
  end

  logic [31:0]      func_reg, func_next;
  logic [31:0]      dir_reg, dir_next;
  logic [31:0]      data_out_reg, data_out_next;
  logic [31:0]      sampled_reg;
  logic [31:0]      pin_sync;
  logic [CNT_W-1:0] cnt_reg;
  logic             sample_tick;
  logic [31:0]      alt_val;
  logic [31:0]      pin_out_next, pin_oe_next;
  logic [4:0]       irq_pin, irq_alt, irq_next;
  logic             wr_func, wr_dir, wr_data, hit;
  logic [31:0]      rdata_next;

  // pin levels cross into the core clock
  sgp_sync #(
    .WIDTH (32)
  ) u_sync (
    .clock (clock),
    .rst_b (rst_b),
    .d     (pin_in),
    .q     (pin_sync)
  );

  // address decode of the upstream configuration space
  assign wr_func = cfg_req.req && cfg_req.wr && (cfg_req.addr == `SGP_OFF_FUNC);
  assign wr_dir  = cfg_req.req && cfg_req.wr && (cfg_req.addr == `SGP_OFF_DIR);
  assign wr_data = cfg_req.req && cfg_req.wr && (cfg_req.addr == `SGP_OFF_DATA);
  assign hit     = (cfg_req.addr == `SGP_OFF_FUNC) || (cfg_req.addr == `SGP_OFF_DIR)
                || (cfg_req.addr == `SGP_OFF_DATA);

  // register next values, one bit per pin
  assign func_next     = wr_func ? cfg_req.wdata : func_reg;
  assign dir_next      = wr_dir  ? cfg_req.wdata : dir_reg;
  assign data_out_next = wr_data ? cfg_req.wdata : data_out_reg;

  // read data: the data register always shows the sampled pin level
  assign rdata_next = (cfg_req.addr == `SGP_OFF_FUNC) ? func_reg :
                      (cfg_req.addr == `SGP_OFF_DIR)  ? dir_reg  :
                      (cfg_req.addr == `SGP_OFF_DATA) ? sampled_reg :
                      32'h0000_0000;

  // sample strobe no more often than the least interval
  assign sample_tick = (cnt_reg == CNT_LAST);

  // alternate output values; pins without an output alternate idle high
  always_comb begin
    alt_val = 32'hFFFF_FFFF;
    alt_val[`SGP_PIN_EVENT] = event_src_n;
    alt_val[`SGP_PIN_DRST_LO +: `SGP_NUM_DRST] = down_reset_src_n;
  end

  // pin role decode: function bit first, then direction
  assign pin_oe_next  = (~func_reg & dir_reg) | (func_reg & `SGP_ALT_OUT_MASK);
  assign pin_out_next = (func_reg & alt_val) | (~func_reg & data_out_reg);

  // expander interrupts: sampled pin in alternate role, else inactive high
  assign irq_pin = {sampled_reg[`SGP_PIN_IRQ10], sampled_reg[`SGP_PIN_IRQ0 +: 4]};
  assign irq_alt = {func_reg[`SGP_PIN_IRQ10], func_reg[`SGP_PIN_IRQ0 +: 4]};
  assign irq_next = irq_pin | ~irq_alt;

  // configuration registers
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      func_reg     <= `SGP_RST_FUNC;
      dir_reg      <= `SGP_RST_DIR;
      data_out_reg <= `SGP_RST_DATA;
    end else begin
      func_reg     <= func_next;
      dir_reg      <= dir_next;
      data_out_reg <= data_out_next;
    end
  end

  // interval counter and sampled pin levels
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      cnt_reg     <= '0;
      sampled_reg <= 32'h0000_0000;
    end else begin
      cnt_reg <= sample_tick ? '0 : cnt_reg + CNT_W'(1);
      if (sample_tick) begin
        sampled_reg <= pin_sync;
      end
    end
  end

  // registered pin drive and alternate inputs
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      pin_oe         <= '0;
      pin_out        <= '0;
      expander_irq_n <= 5'h1F;
    end else begin
      pin_oe         <= pin_oe_next;
      pin_out        <= pin_out_next;
      expander_irq_n <= irq_next;
    end
  end

  // configuration answer, one cycle after the access
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      cfg_rsp <= '0;
    end else begin
      cfg_rsp.ack   <= cfg_req.req;
      cfg_rsp.hit   <= cfg_req.req && hit;
      cfg_rsp.rdata <= (cfg_req.req && !cfg_req.wr) ? rdata_next : 32'h0000_0000;
    end
  end

  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);

  logic [7:0] gap_reg;
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      gap_reg <= '0;
    end else begin
      gap_reg <= sample_tick ? 8'h00 : gap_reg + 8'h01;
    end
  end

  property p_reset_inputs;
    $rose(rst_b) |-> (pin_oe == '0) && (func_reg == '0) && (expander_irq_n == 5'h1F);
  endproperty
  a_reset_inputs: assert property (p_reset_inputs) else $error("pin not input after reset");

  property p_role_decode;
    ##1 pin_oe == $past((~func_reg & dir_reg) | (func_reg & 32'h0000_1FE0));
  endproperty
  a_role_decode: assert property (p_role_decode) else $error("pin enable disagrees with role");

  property p_sample_gap;
    sample_tick |-> ##1 !sample_tick [*5];
  endproperty
  a_sample_gap: assert property (p_sample_gap) else $error("pins sampled too often");

  property p_sample_due;
    gap_reg <= 8'(SAMPLE_CYC - 1);
  endproperty
  a_sample_due: assert property (p_sample_due) else $error("sampling interval too long");

  property p_irq_idle;
    !func_reg[21] |=> expander_irq_n[0];
  endproperty
  a_irq_idle: assert property (p_irq_idle) else $error("unused alternate not held inactive");

  property p_data_read;
    (cfg_req.req && !cfg_req.wr && cfg_req.addr == `SGP_OFF_DATA) |=>
      cfg_rsp.ack && cfg_rsp.rdata == $past(sampled_reg);
  endproperty
  a_data_read: assert property (p_data_read) else $error("data read not sampled level");

  property p_gp_out;
    (!func_reg[0] && dir_reg[0]) |=> pin_oe[0] && pin_out[0] == $past(data_out_reg[0]);
  endproperty
  a_gp_out: assert property (p_gp_out) else $error("general output not driven");

  property p_event_out;
    func_reg[5] |=> pin_oe[5] && pin_out[5] == $past(event_src_n);
  endproperty
  a_event_out: assert property (p_event_out) else $error("event output not driven");

  property p_down_reset;
    func_reg[12] |=> pin_oe[12] && pin_out[12] == $past(down_reset_src_n[6]);
  endproperty
  a_down_reset: assert property (p_down_reset) else $error("downstream reset 7 wrong");

  property p_irq_alt;
    (func_reg[31] && sample_tick) ##1 func_reg[31] |=> expander_irq_n[4] == $past(pin_sync[31], 2);
  endproperty
  a_irq_alt: assert property (p_irq_alt) else $error("expander interrupt 10 not passed");

  property p_sync_capture;
    sample_tick |=> sampled_reg == $past(pin_sync);
  endproperty
  a_sync_capture: assert property (p_sync_capture) else $error("sample not captured");

  c_func_write: cover property (wr_func ##1 func_reg != '0);
  c_gp_output:  cover property (wr_data ##2 pin_oe != '0);
  c_irq_seen:   cover property (func_reg[22] && !expander_irq_n[1]);
  c_unmapped:   cover property (cfg_rsp.ack && !cfg_rsp.hit);

endmodule

`default_nettype wire

/* File: sgp_board_model.sv */
// sgp_board_model.sv: board parts wired to the port's pins.
// assumes: a pin is driven by the port when enabled, else by a board source.
`timescale 1ns/100ps
`default_nettype none

module sgp_board_model (
  // port side
  input  wire logic [31:0] pin_out,
  input  wire logic [31:0] pin_oe,
  // board sources
  input  wire logic [31:0] ext_level,
  // resolved wire levels
  output var  logic [31:0] pin_level
);
  // the port wins where it drives; elsewhere the board source sets the level
  assign pin_level = (pin_out & pin_oe) | (ext_level & ~pin_oe);
endmodule

`default_nettype wire

/* File: sgp_gpio_port_bench.sv */
// sgp_gpio_port_bench.sv: self-checking bench for the general purpose port.
// assumes: sgp_pkg and the design files are compiled first.
`timescale 1ns/100ps
`default_nettype none
`include "sgp_consts.svh"
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin miscompares++; \
  $display("CHECK FAILED %s expected %h seen %h", nm, e, g); end end

module sgp_gpio_port_bench;
  logic                  clock;
  logic                  rst_b;
  sgp_pkg::sgp_cfg_req_t cfg_req;
  sgp_pkg::sgp_cfg_rsp_t cfg_rsp;
  logic [31:0]           pin_level, pin_out, pin_oe, ext_level, rd, rnd;
  logic [31:0]           f, d, w, eoe, eout, elvl;
  logic                  event_src_n;
  logic [6:0]            down_reset_src_n;
  logic [4:0]            expander_irq_n, eirq;
  int                    miscompares, compares;

  // device under test and the board around it
  sgp_gpio_port uut (
    .clock(clock), .rst_b(rst_b), .cfg_req(cfg_req), .cfg_rsp(cfg_rsp),
    .pin_in(pin_level), .pin_out(pin_out), .pin_oe(pin_oe), .event_src_n(event_src_n),
    .down_reset_src_n(down_reset_src_n), .expander_irq_n(expander_irq_n));
  sgp_board_model board (.pin_out(pin_out), .pin_oe(pin_oe), .ext_level(ext_level),
    .pin_level(pin_level));

  // 40 MHz core clock
  initial clock = 1'b0;
  always #12.5 clock = ~clock;

  // pseudo-random source, fixed start
  function automatic logic [31:0] next_rand(input logic [31:0] s);
    next_rand = s[0] ? ((s >> 1) ^ 32'h8020_0003) : (s >> 1);
  endfunction

  // drive enable: general outputs plus alternate output pins 5..12
  function automatic logic [31:0] exp_oe(input logic [31:0] fn, input logic [31:0] dr);
    exp_oe = (~fn & dr) | (fn & `SGP_ALT_OUT_MASK);
  endfunction

  // drive value: data latch for general outputs, internal sources for alternates
  function automatic logic [31:0] exp_out(input logic [31:0] fn, input logic [31:0] wd,
                                          input logic [7:0] src);
    exp_out = (~fn & wd) | (fn & {19'h0_0000, src, 5'h00});
  endfunction

  // one configuration access; the answer stands only in the cycle after
  // the taking edge, so it is looked at just after that edge
  task automatic cfg(input logic wr, input logic [`SGP_ADDR_W-1:0] a,
                     input logic [31:0] wd, input logic ehit);
    @(posedge clock);
    cfg_req <= '{req: 1'b1, wr: wr, addr: a, wdata: wd};
    @(posedge clock);
    cfg_req.req <= 1'b0;
    #1;
    `CHK("ack", 1'b1, cfg_rsp.ack)
    `CHK("hit", ehit, cfg_rsp.hit)
    rd = cfg_rsp.rdata;
  endtask

  // reset for 20 cycles, then confirm the idle input setup
  task automatic do_reset();
    @(posedge clock);
    rst_b <= 1'b0;
    repeat (20) @(posedge clock);
    `CHK("oe in reset", 32'h0000_0000, pin_oe)
    `CHK("irq in reset", 5'h1f, expander_irq_n)
    rst_b <= 1'b1;
    cfg(1'b0, `SGP_OFF_FUNC, 32'h0000_0000, 1'b1);
    `CHK("func reset", 32'h0000_0000, rd)
    cfg(1'b0, `SGP_OFF_DIR, 32'h0000_0000, 1'b1);
    `CHK("dir reset", 32'h0000_0000, rd)
  endtask

  // verdict and end of run
  task automatic print_verdict();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // watchdog against a hung access
  initial begin
    repeat (8000) @(posedge clock);
    miscompares++;
    print_verdict();
  end

  // main sequence: corner setups first, then random ones
  initial begin
    rst_b = 1'b0;
    cfg_req = '0;
    event_src_n = 1'b1;
    down_reset_src_n = 7'h7f;
    ext_level = 32'h0000_0000;
    rnd = 32'h0000_0006;
    miscompares = 0;
    compares = 0;
    do_reset();
    cfg(1'b1, 12'h3fc, 32'hffff_ffff, 1'b0);
    cfg(1'b0, 12'h3fc, 32'h0000_0000, 1'b0);
    `CHK("unmapped read", 32'h0000_0000, rd)
    cfg(1'b0, `SGP_OFF_FUNC, 32'h0000_0000, 1'b1);
    `CHK("unmapped write ignored", 32'h0000_0000, rd)
    for (int i = 0; i < 24; i++) begin
      rnd = next_rand(rnd);
      f = (i == 0) ? 32'hffff_ffff : (i == 1) ? 32'h0000_0000 : rnd;
      rnd = next_rand(rnd);
      d = (i == 1) ? 32'hffff_ffff : rnd;
      rnd = next_rand(rnd);
      w = rnd;
      rnd = next_rand(rnd);
      @(posedge clock);
      ext_level <= rnd;
      event_src_n <= rnd[3];
      down_reset_src_n <= rnd[14:8];
      cfg(1'b1, `SGP_OFF_FUNC, f, 1'b1);
      cfg(1'b1, `SGP_OFF_DIR, d, 1'b1);
      cfg(1'b1, `SGP_OFF_DATA, w, 1'b1);
      repeat (16) @(posedge clock);
      #1;
      eoe = exp_oe(f, d);
      eout = exp_out(f, w, {down_reset_src_n, event_src_n});
      elvl = (eout & eoe) | (ext_level & ~eoe);
      eirq = ~{f[31], f[24:21]} | {elvl[31], elvl[24:21]};
      `CHK("pin_oe", eoe, pin_oe)
      `CHK("pin_out", eout & eoe, pin_out & eoe)
      `CHK("irq", eirq, expander_irq_n)
      cfg(1'b0, `SGP_OFF_FUNC, 32'h0000_0000, 1'b1);
      `CHK("func", f, rd)
      cfg(1'b0, `SGP_OFF_DIR, 32'h0000_0000, 1'b1);
      `CHK("dir", d, rd)
      cfg(1'b0, `SGP_OFF_DATA, 32'h0000_0000, 1'b1);
      `CHK("data", elvl, rd)
    end
    do_reset();
    print_verdict();
  end
endmodule

`default_nettype wire
